/* design/prf_top.sv */
`timescale 1ns/10ps
// How it works
// - when the lock bit is 1, writes to the ramp register are dropped without notice.
// - with channel 3 smoothing on, its duty walks toward the target instead of jumping.
// - channel 3 rate code maps to steps 1,2,3,5,8,12,24,48.
// - one time slot is sized so step 1 takes about 35 s across 33 to 100 percent.
// - bit 3 turns channel 3 ramping on; off means the duty jumps at once.
// - bits 6 to 4 hold channel 2 rate code with the same mapping.
// - bit 7 turns channel 2 ramping on.
// - reset clears the ramp register to zero.
// - floor value is linear duty, 0x00 off, 0xff full.
// - floor registers are read-only in automatic fan control mode.
module prf_top #(
  parameter int SLOT_LEN = prf_pkg::SLOT_CYCLES
) (
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic [7:0]  ADDRESS,
  input  wire logic        READ,
  input  wire logic        WRITE,
  input  wire logic [31:0] WRITEDATA,
  output logic [31:0]      READDATA,
  output logic             WAITREQUEST,
  output logic [7:0]       PWM2_DUTY,
  output logic [7:0]       PWM3_DUTY,
  output logic [7:0]       PWM1_FLOOR,
  output logic [7:0]       PWM2_FLOOR,
  output logic [7:0]       PWM3_FLOOR
);

  prf_pkg::prf_state_type s_r;
  prf_pkg::prf_state_type s_nxt;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] step_of(input logic [2:0] code);
    case (code)
      3'h0: step_of = 8'h01;
      3'h1: step_of = 8'h02;
      3'h2: step_of = 8'h03;
      3'h3: step_of = 8'h05;
      3'h4: step_of = 8'h08;
      3'h5: step_of = 8'h0c;
      3'h6: step_of = 8'h18;
      default: step_of = 8'h30;
    endcase
  endfunction : step_of

  // clamped walk: never passes the target
  function automatic logic [7:0] walk(input logic [7:0] cur, input logic [7:0] tgt,
                                      input logic [7:0] stp);
    logic [7:0] gap;
    gap = 8'h00;
    if (cur < tgt) begin
      gap = tgt - cur;
      walk = (gap <= stp) ? tgt : cur + stp;
    end else begin
      gap = cur - tgt;
      walk = (gap <= stp) ? tgt : cur - stp;
    end
  endfunction : walk

  logic slot_tick;
  logic wr_ok;
  logic locked;
  logic auto_mode;
  // the slot counter runs free, so a new target may wait up to one slot
  // before its first step; the lag is traded for a single shared counter
  assign slot_tick = (s_r.slot_cnt == 32'(SLOT_LEN - 1));
  assign locked    = s_r.ctrl[prf_pkg::LOCK_BIT];
  assign auto_mode = s_r.ctrl[prf_pkg::AUTO_BIT];
  // every access waits one cycle; a write lands at the edge that ends the
  // answer cycle, the same edge at which the master sees waitrequest low
  assign wr_ok     = WRITE && !READ && !WAITREQUEST;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.rvalid = 1'b0;
    s_nxt.wait_req = 1'b1;
    s_nxt.slot_cnt = slot_tick ? 32'h0 : s_r.slot_cnt + 32'h1;

    if (WAITREQUEST && (READ || WRITE)) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.wait_req = 1'b0;
    end

    if (wr_ok) begin
      case (ADDRESS)
        prf_pkg::ADDR_RAMP_CTRL: begin
          if (!locked) begin
            s_nxt.ramp = WRITEDATA[7:0];
          end
        end
        prf_pkg::ADDR_CTRL: begin
          // lock is sticky until reset
          s_nxt.ctrl[prf_pkg::LOCK_BIT] = locked | WRITEDATA[prf_pkg::LOCK_BIT];
          s_nxt.ctrl[prf_pkg::AUTO_BIT] = WRITEDATA[prf_pkg::AUTO_BIT];
        end
        prf_pkg::ADDR_FLOOR1: if (!auto_mode) s_nxt.floor1 = WRITEDATA[7:0];
        prf_pkg::ADDR_FLOOR2: if (!auto_mode) s_nxt.floor2 = WRITEDATA[7:0];
        prf_pkg::ADDR_FLOOR3: if (!auto_mode) s_nxt.floor3 = WRITEDATA[7:0];
        prf_pkg::ADDR_TARGET2: s_nxt.target2 = WRITEDATA[7:0];
        prf_pkg::ADDR_TARGET3: s_nxt.target3 = WRITEDATA[7:0];
        default: ;
      endcase
    end

    // with ramping on, a new target is picked up at the next slot edge; with it off, the duty takes it at once
    // channel 2 duty
    if (!s_r.ramp[prf_pkg::CH2_ON_BIT]) begin
      s_nxt.duty2 = s_nxt.target2;
    end else if (slot_tick) begin
      s_nxt.duty2 = walk(s_r.duty2, s_r.target2,
                         step_of(s_r.ramp[prf_pkg::CH2_RATE_LSB +: 3]));
    end

    // channel 3 duty
    if (!s_r.ramp[prf_pkg::CH3_ON_BIT]) begin
      s_nxt.duty3 = s_nxt.target3;
    end else if (slot_tick) begin
      s_nxt.duty3 = walk(s_r.duty3, s_r.target3,
                         step_of(s_r.ramp[prf_pkg::CH3_RATE_LSB +: 3]));
    end

    s_nxt.rdata = 32'h0;
    case (ADDRESS)
      prf_pkg::ADDR_RAMP_CTRL: s_nxt.rdata = {24'h0, s_r.ramp};
      prf_pkg::ADDR_CTRL:      s_nxt.rdata = {30'h0, s_r.ctrl};
      prf_pkg::ADDR_FLOOR1:    s_nxt.rdata = {24'h0, s_r.floor1};
      prf_pkg::ADDR_FLOOR2:    s_nxt.rdata = {24'h0, s_r.floor2};
      prf_pkg::ADDR_FLOOR3:    s_nxt.rdata = {24'h0, s_r.floor3};
      prf_pkg::ADDR_TARGET2:   s_nxt.rdata = {24'h0, s_r.target2};
      prf_pkg::ADDR_TARGET3:   s_nxt.rdata = {24'h0, s_r.target3};
      prf_pkg::ADDR_DUTY2:     s_nxt.rdata = {24'h0, s_r.duty2};
      prf_pkg::ADDR_DUTY3:     s_nxt.rdata = {24'h0, s_r.duty3};
      default:                 s_nxt.rdata = 32'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      s_r.ramp     <= prf_pkg::RAMP_RESET;
      s_r.ctrl     <= 2'h0;
      s_r.floor1   <= prf_pkg::FLOOR_RESET;
      s_r.floor2   <= prf_pkg::FLOOR_RESET;
      s_r.floor3   <= prf_pkg::FLOOR_RESET;
      s_r.target2  <= prf_pkg::DUTY_RESET;
      s_r.target3  <= prf_pkg::DUTY_RESET;
      s_r.duty2    <= prf_pkg::DUTY_RESET;
      s_r.duty3    <= prf_pkg::DUTY_RESET;
      s_r.slot_cnt <= 32'h0;
      s_r.rdata    <= 32'h0;
      s_r.rvalid   <= 1'b0;
      s_r.wait_req <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign WAITREQUEST = s_r.wait_req;
  assign READDATA   = s_r.rdata;
  assign PWM2_DUTY  = s_r.duty2;
  assign PWM3_DUTY  = s_r.duty3;
  assign PWM1_FLOOR = s_r.floor1;
  assign PWM2_FLOOR = s_r.floor2;
  assign PWM3_FLOOR = s_r.floor3;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence locked_ramp_write;
    locked && wr_ok && ADDRESS == prf_pkg::ADDR_RAMP_CTRL;
  endsequence

  chk_lock_holds_ramp: assert property (@(posedge CLK) disable iff (RESET)
    locked_ramp_write |=> $stable(s_r.ramp))
    else $error("ramp register changed while locked");

  chk_unlock_writes: assert property (@(posedge CLK) disable iff (RESET)
    (!locked && wr_ok && ADDRESS == prf_pkg::ADDR_RAMP_CTRL) |=>
      s_r.ramp == $past(WRITEDATA[7:0]))
    else $error("ramp write lost while unlocked");

  chk_ch3_bypass: assert property (@(posedge CLK) disable iff (RESET)
    !s_r.ramp[prf_pkg::CH3_ON_BIT] |-> ##1
      (s_r.ramp[prf_pkg::CH3_ON_BIT] || s_r.duty3 == s_r.target3))
    else $error("channel 3 not bypassed");

  chk_ch3_hold: assert property (@(posedge CLK) disable iff (RESET)
    (s_r.ramp[prf_pkg::CH3_ON_BIT] && !slot_tick) |=> $stable(s_r.duty3))
    else $error("channel 3 moved between slots");

  chk_ch2_hold: assert property (@(posedge CLK) disable iff (RESET)
    (s_r.ramp[prf_pkg::CH2_ON_BIT] && !slot_tick) |=> $stable(s_r.duty2))
    else $error("channel 2 moved between slots");

  chk_ch3_step: assert property (@(posedge CLK) disable iff (RESET)
    (s_r.ramp[prf_pkg::CH3_ON_BIT] && slot_tick && s_r.duty3 < s_r.target3) |=>
      s_r.duty3 <= $past(s_r.target3) &&
      s_r.duty3 - $past(s_r.duty3) <= step_of($past(s_r.ramp[2:0])))
    else $error("channel 3 overshoot or wrong step");

  chk_ch3_rate: assert property (@(posedge CLK) disable iff (RESET)
    (s_r.ramp[prf_pkg::CH3_ON_BIT] && s_r.ramp[2:0] == 3'h7 && slot_tick &&
     s_r.target3 >= s_r.duty3 + 8'h30 && s_r.duty3 < 8'h80) |=>
      s_r.duty3 == $past(s_r.duty3) + 8'h30)
    else $error("fastest code is not step 48");

  chk_floor_auto: assert property (@(posedge CLK) disable iff (RESET)
    (auto_mode && wr_ok && ADDRESS == prf_pkg::ADDR_FLOOR1) |=> $stable(s_r.floor1))
    else $error("floor written in automatic mode");

  chk_slot_len: assert property (@(posedge CLK) disable iff (RESET)
    s_r.slot_cnt < 32'(SLOT_LEN))
    else $error("slot counter past its length");

  chk_slot_wrap: assert property (@(posedge CLK) disable iff (RESET)
    slot_tick |=> s_r.slot_cnt == 32'h0)
    else $error("slot counter did not wrap");

  // ----------------------------------------------------------------
  // checks: bus handshake
  // ----------------------------------------------------------------
  // a request is taken while waitrequest is high and answered one cycle
  // later; a second answer cycle would let the master take stale data
  sequence bus_taken;
    (READ || WRITE) && WAITREQUEST;
  endsequence

  sequence bus_answer;
    !WAITREQUEST && s_r.rvalid;
  endsequence

  chk_bus_answer: assert property (@(posedge CLK) disable iff (RESET)
    bus_taken |=> bus_answer)
    else $error("request not answered after one wait cycle");

  chk_bus_release: assert property (@(posedge CLK) disable iff (RESET)
    bus_answer |=> WAITREQUEST)
    else $error("answer cycle lasted more than one cycle");

  // ----------------------------------------------------------------
  // checks: registers
  // ----------------------------------------------------------------
  // no disable here: these look at the first edge after release
  chk_reset_values: assert property (@(posedge CLK)
    $fell(RESET) |-> s_r.ramp == prf_pkg::RAMP_RESET && WAITREQUEST)
    else $error("ramp register not cleared by reset");

  chk_floor_reset: assert property (@(posedge CLK)
    $fell(RESET) |-> s_r.floor1 == prf_pkg::FLOOR_RESET &&
      s_r.floor2 == prf_pkg::FLOOR_RESET && s_r.floor3 == prf_pkg::FLOOR_RESET)
    else $error("floor register not at its reset value");

  chk_lock_sticky: assert property (@(posedge CLK) disable iff (RESET)
    locked |=> locked)
    else $error("lock bit cleared without reset");

  chk_floor_write: assert property (@(posedge CLK) disable iff (RESET)
    (!auto_mode && wr_ok && ADDRESS == prf_pkg::ADDR_FLOOR2) |=>
      s_r.floor2 == $past(WRITEDATA[7:0]))
    else $error("floor write lost outside automatic mode");

  chk_floor2_auto: assert property (@(posedge CLK) disable iff (RESET)
    (auto_mode && wr_ok && ADDRESS == prf_pkg::ADDR_FLOOR2) |=> $stable(s_r.floor2))
    else $error("floor written in automatic mode");

  chk_floor3_auto: assert property (@(posedge CLK) disable iff (RESET)
    (auto_mode && wr_ok && ADDRESS == prf_pkg::ADDR_FLOOR3) |=> $stable(s_r.floor3))
    else $error("floor written in automatic mode");

  // read data are captured in the wait cycle, so they show the register
  // as it stood when the request was taken
  chk_read_floor: assert property (@(posedge CLK) disable iff (RESET)
    (READ && WAITREQUEST && ADDRESS == prf_pkg::ADDR_FLOOR3) |=>
      READDATA == {24'h0, $past(s_r.floor3)})
    else $error("floor read returned the wrong value");

  chk_read_ramp: assert property (@(posedge CLK) disable iff (RESET)
    (READ && WAITREQUEST && ADDRESS == prf_pkg::ADDR_RAMP_CTRL) |=>
      READDATA == {24'h0, $past(s_r.ramp)})
    else $error("ramp register read returned the wrong value");

  // ----------------------------------------------------------------
  // checks: ramp steps
  // ----------------------------------------------------------------
  // a slot edge with the duty still short of, or beyond, its target
  sequence ch2_slot_up;
    s_r.ramp[prf_pkg::CH2_ON_BIT] && slot_tick && s_r.duty2 < s_r.target2;
  endsequence

  sequence ch2_slot_down;
    s_r.ramp[prf_pkg::CH2_ON_BIT] && slot_tick && s_r.duty2 > s_r.target2;
  endsequence

  sequence ch3_slot_up;
    s_r.ramp[prf_pkg::CH3_ON_BIT] && slot_tick && s_r.duty3 < s_r.target3;
  endsequence

  sequence ch3_slot_down;
    s_r.ramp[prf_pkg::CH3_ON_BIT] && slot_tick && s_r.duty3 > s_r.target3;
  endsequence

  chk_ch2_bypass: assert property (@(posedge CLK) disable iff (RESET)
    !s_r.ramp[prf_pkg::CH2_ON_BIT] |=>
      (s_r.ramp[prf_pkg::CH2_ON_BIT] || s_r.duty2 == s_r.target2))
    else $error("channel 2 not bypassed");

  chk_ch2_up: assert property (@(posedge CLK) disable iff (RESET)
    ch2_slot_up |=> s_r.duty2 > $past(s_r.duty2) && s_r.duty2 <= $past(s_r.target2) &&
      s_r.duty2 - $past(s_r.duty2) <= step_of($past(s_r.ramp[prf_pkg::CH2_RATE_LSB +: 3])))
    else $error("channel 2 overshoot or wrong step upward");

  chk_ch2_down: assert property (@(posedge CLK) disable iff (RESET)
    ch2_slot_down |=> s_r.duty2 < $past(s_r.duty2) && s_r.duty2 >= $past(s_r.target2) &&
      $past(s_r.duty2) - s_r.duty2 <= step_of($past(s_r.ramp[prf_pkg::CH2_RATE_LSB +: 3])))
    else $error("channel 2 overshoot or wrong step downward");

  chk_ch3_down: assert property (@(posedge CLK) disable iff (RESET)
    ch3_slot_down |=> s_r.duty3 < $past(s_r.duty3) && s_r.duty3 >= $past(s_r.target3) &&
      $past(s_r.duty3) - s_r.duty3 <= step_of($past(s_r.ramp[prf_pkg::CH3_RATE_LSB +: 3])))
    else $error("channel 3 overshoot or wrong step downward");

  chk_ch3_moves: assert property (@(posedge CLK) disable iff (RESET)
    ch3_slot_up |=> s_r.duty3 > $past(s_r.duty3))
    else $error("channel 3 did not step toward its target");

  // slowest code: every slot moves exactly one count, either way
  chk_ch2_rate: assert property (@(posedge CLK) disable iff (RESET)
    (s_r.ramp[prf_pkg::CH2_ON_BIT] && s_r.ramp[prf_pkg::CH2_RATE_LSB +: 3] == 3'h0 &&
     slot_tick && s_r.duty2 != s_r.target2) |=>
      (s_r.duty2 - $past(s_r.duty2) == 8'h01) || ($past(s_r.duty2) - s_r.duty2 == 8'h01))
    else $error("slowest code is not step 1");

endmodule : prf_top

/* pkg/prf_pkg.sv */
package prf_pkg;

  // ----------------------------------------------------------------
  // register map (word addresses, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_RAMP_CTRL  = 8'h62;
  localparam logic [7:0] ADDR_CTRL       = 8'h60;
  localparam logic [7:0] ADDR_FLOOR1     = 8'h64;
  localparam logic [7:0] ADDR_FLOOR2     = 8'h65;
  localparam logic [7:0] ADDR_FLOOR3     = 8'h66;
  localparam logic [7:0] ADDR_TARGET2    = 8'h68;
  localparam logic [7:0] ADDR_TARGET3    = 8'h69;
  localparam logic [7:0] ADDR_DUTY2      = 8'h6a;
  localparam logic [7:0] ADDR_DUTY3      = 8'h6b;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CH3_RATE_LSB = 0;
  localparam int CH3_ON_BIT   = 3;
  localparam int CH2_RATE_LSB = 4;
  localparam int CH2_ON_BIT   = 7;
  localparam int LOCK_BIT     = 0;
  localparam int AUTO_BIT     = 1;
  localparam logic [7:0] RAMP_RESET  = 8'h00;
  localparam logic [7:0] FLOOR_RESET = 8'h80;
  localparam logic [7:0] DUTY_RESET  = 8'h00;

  // ----------------------------------------------------------------
  // timing: a 33% to 100% swing is 171 duty steps; 35 s at step 1
  // ----------------------------------------------------------------
  localparam int  CLK_HZ       = 40_000_000;
  localparam int  SLOW_RAMP_MS = 35_000;
  localparam int  SWING_STEPS  = 171;
  localparam longint SLOT_CYCLES_L =
    (longint'(SLOW_RAMP_MS) * longint'(CLK_HZ)) / (longint'(1000) * SWING_STEPS);
  localparam int  SLOT_CYCLES  = int'(SLOT_CYCLES_L);

  typedef struct packed {
    logic [7:0] ramp;
    logic [1:0] ctrl;
    logic [7:0] floor1;
    logic [7:0] floor2;
    logic [7:0] floor3;
    logic [7:0] target2;
    logic [7:0] target3;
    logic [7:0] duty2;
    logic [7:0] duty3;
    logic [31:0] slot_cnt;
    logic [31:0] rdata;
    logic        rvalid;
    logic        wait_req;
  } prf_state_type;

endpackage : prf_pkg

/* verif/prf_fan_model.sv */
`timescale 1ns/10ps
// fan inertia: speed creeps one count per clock toward the duty it is fed;
// no spin-up kick is modelled, software keeps it off on ramped channels
module prf_fan_model (
  input  wire logic       CLK,
  input  wire logic       RESET,
  input  wire logic [7:0] DUTY,
  output logic      [7:0] SPEED
);
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) SPEED <= 8'h00;
    else if (SPEED < DUTY) SPEED <= SPEED + 8'h01;
    else if (SPEED > DUTY) SPEED <= SPEED - 8'h01;
  end
endmodule : prf_fan_model

/* verif/test_pwm_ramp_and_floor_duty.sv */
`timescale 1ns/10ps
`define PRF_CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module test_pwm_ramp_and_floor_duty;
  logic            CLK = 1'b0;
  logic            RESET = 1'b1;
  logic [7:0]      ADDRESS = 8'h00;
  logic            READ = 1'b0;
  logic            WRITE = 1'b0;
  logic [31:0]     WRITEDATA = 32'h00000000;
  logic [31:0]     READDATA;
  logic            WAITREQUEST;
  logic [7:0]      PWM2_DUTY, PWM3_DUTY, PWM1_FLOOR, PWM2_FLOOR, PWM3_FLOOR;
  logic [2:0][7:0] fl;
  logic [31:0]     exp_q[$];
  logic [7:0]      stp[8] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h08, 8'h0c, 8'h18, 8'h30};
  logic [7:0]      lin[3] = '{8'h00, 8'h40, 8'hff};
  logic [7:0]      v[3];
  int              err_count = 0;
  int              compares = 0;
  localparam int   SLOT = 4;
  always #12.5 CLK = ~CLK;
  assign fl = {PWM3_FLOOR, PWM2_FLOOR, PWM1_FLOOR};
  prf_top #(.SLOT_LEN(SLOT)) u_prf_top (.CLK(CLK), .RESET(RESET), .ADDRESS(ADDRESS),
    .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA), .READDATA(READDATA),
    .WAITREQUEST(WAITREQUEST), .PWM2_DUTY(PWM2_DUTY), .PWM3_DUTY(PWM3_DUTY),
    .PWM1_FLOOR(PWM1_FLOOR), .PWM2_FLOOR(PWM2_FLOOR), .PWM3_FLOOR(PWM3_FLOOR));
  prf_fan_model u_prf_fan_model2 (.CLK(CLK), .RESET(RESET), .DUTY(PWM2_DUTY), .SPEED());
  prf_fan_model u_prf_fan_model3 (.CLK(CLK), .RESET(RESET), .DUTY(PWM3_DUTY), .SPEED());
  // ----------------------------------------------------------------
  // bus master and read scoreboard
  // ----------------------------------------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge CLK);
    ADDRESS <= a;
    WRITEDATA <= {24'h000000, d};
    WRITE <= w;
    READ <= ~w;
    do begin
      @(posedge CLK);
      n++;
    end while (WAITREQUEST !== 1'b0 && n < 50);
    if (WAITREQUEST !== 1'b0) begin
      err_count++;
      print_verdict();
    end
    WRITE <= 1'b0;
    READ <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({24'h000000, e});
    bus(1'b0, a, 8'h00);
  endtask : rd
  // read data are checked in the cycle waitrequest is low, the first cycle they stand
  always @(posedge CLK) begin
    if (READ && WAITREQUEST === 1'b0 && exp_q.size() > 0) begin
      `PRF_CHK(READDATA, exp_q[0])
      void'(exp_q.pop_front());
    end
  end
  task automatic ramp(input int ch, input logic [2:0] code);
    logic [7:0] a, fr, to, prv, cur, st, ex;
    int         last;
    a = (ch == 2) ? 8'h68 : 8'h69;
    fr = 8'($urandom);
    to = fr + 8'(1 + $urandom % 255);
    st = stp[code];
    wr(8'h62, 8'h00);
    wr(a, fr);
    #1 cur = (ch == 2) ? PWM2_DUTY : PWM3_DUTY;
    `PRF_CHK(cur, fr)
    wr(8'h62, (ch == 2) ? {1'b1, code, 4'h0} : {4'h0, 1'b1, code});
    wr(a, to);
    prv = fr;
    last = -1;
    for (int n = 0; n < 3000 && prv !== to; n++) begin
      #1 cur = (ch == 2) ? PWM2_DUTY : PWM3_DUTY;
      if (cur !== prv) begin
        ex = (to > prv) ? ((to - prv < st) ? to : prv + st) : ((prv - to < st) ? to : prv - st);
        `PRF_CHK(cur, ex)
        if (last >= 0) `PRF_CHK(n - last, SLOT)
        last = n;
        prv = cur;
      end
      @(posedge CLK);
    end
    `PRF_CHK(cur, to)
  endtask : ramp
  task automatic print_verdict;
    if (exp_q.size() != 0) err_count++;
    $display("counts: compares=%0d mismatches=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (60000) @(posedge CLK);
    err_count++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'hb272bc00));
    repeat (16) @(posedge CLK);
    RESET <= 1'b0;
    rd(8'h62, 8'h00);
    for (int i = 0; i < 3; i++) rd(8'h64 + 8'(i), 8'h80);
    rd(8'h7f, 8'h00);
    $display("test reset values done");
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 3; i++) begin
        v[i] = p ? 8'($urandom) : lin[i];
        wr(8'h64 + 8'(i), v[i]);
        rd(8'h64 + 8'(i), v[i]);
        `PRF_CHK(fl[i], v[i])
      end
    end
    $display("test floor registers done");
    for (int c = 0; c < 16; c++) ramp(c[3] ? 2 : 3, c[2:0]);
    $display("test ramp codes done");
    wr(8'h60, 8'h02);
    for (int i = 0; i < 3; i++) begin
      wr(8'h64 + 8'(i), v[i] ^ 8'h5a);
      rd(8'h64 + 8'(i), v[i]);
    end
    wr(8'h60, 8'h00);
    wr(8'h62, 8'h5a);
    rd(8'h62, 8'h5a);
    wr(8'h60, 8'h01);
    wr(8'h62, 8'ha5);
    rd(8'h62, 8'h5a);
    wr(8'h60, 8'h00);
    wr(8'h62, 8'h3c);
    rd(8'h62, 8'h5a);
    repeat (4) @(posedge CLK);
    $display("test lock and auto mode done");
    print_verdict();
  end
endmodule : test_pwm_ramp_and_floor_duty
